/* hdl/np_regs.vh */
`ifndef NP_REGS_VH
`define NP_REGS_VH
// Register addresses (5-bit management register numbers)
`define ADDR_EXPANSION       5'h06
`define ADDR_NP_TRANSMIT     5'h07
`define ADDR_PARTNER_NP      5'h08
// Expansion register fields
`define EXP_PAR_FAULT_BIT    4
`define EXP_PARTNER_NP_BIT   3
`define EXP_LOCAL_NP_BIT     2
`define EXP_PAGE_RX_BIT      1
`define EXP_PARTNER_AN_BIT   0
`define EXP_RESET            16'h0004
// Next-page word fields
`define NP_MORE_BIT          15
`define NP_RSVD_BIT          14
`define NP_MSG_BIT           13
`define NP_ACK2_BIT          12
`define NP_TOGGLE_BIT        11
`define NP_CODE_HI           10
`define NP_CODE_LO           0
`define NP_TX_RESET          16'h2001
`define NP_RX_RESET          16'h0000
// Writable mask of the transmit word: toggle and reserved bit excluded
`define NP_TX_WMASK          16'hB7FF
// Per-field reset values of the transmit word, then receive, expansion, flag and read-data constants and word width
`define NP_MORE_RESET        1'b0
`define NP_MSG_RESET         1'b1
`define NP_ACK2_RESET        1'b0
`define NP_TOGGLE_RESET      1'b0
`define NP_CODE_RESET        11'h001
`define NP_RSVD_ZERO         1'b0
`define NP_RX_RESET_BIT      1'b0
`define NP_WORD_WIDTH        16
`define EXP_ZERO             16'h0000
`define LOCAL_NP_ABLE        1'b1
`define FLAG_RESET           1'b0
`define RDATA_RESET          16'h0000
`endif

/* hdl/event_latch.v */
`timescale 1ns/1ps
// Latched-until-read flag; a set in the clearing cycle wins.
module event_latch (
  input  wire clk,
  input  wire rst_n,
  input  wire set,
  input  wire clr,
  output reg  flag_q
);
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flag_q <= 1'b0;
    else if (set)
      flag_q <= 1'b1;
    else if (clr)
      flag_q <= 1'b0;
  end
endmodule

/* hdl/autoneg_next_page_registers.v */
`timescale 1ns/1ps
`include "np_regs.vh"
// Functional notes
// - Expansion register always reports local next-page capability as one.
// - Expansion shows partner next-page ability, zero until partner capability known.
// - Page-received flag latches high on new partner page; resets to zero.
// - Management writes more-pages, message-page and second-acknowledge transmit bits.
// - Transmit toggle bit is device-maintained, read-only, previous word toggle, resets zero.
// - Eleven-bit writable code field; transmit word resets to message-page and bit zero.
// - Partner control bits stored read-only in received register, reset zero.
// - Partner eleven-bit code field captured read-only into received register.
module autoneg_next_page_registers (
  input  wire        clk,
  input  wire        rst_n,
  input  wire [4:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [15:0] reg_wdata,
  output reg  [15:0] reg_rdata_q,
  input  wire        partner_an_able,
  input  wire        partner_ability_valid,
  input  wire        partner_np_able,
  input  wire        page_rx_strobe,
  input  wire [15:0] page_rx_word,
  input  wire        multi_tech_detect,
  input  wire        page_tx_done,
  output wire [15:0] np_tx_word
);

  reg         more_q;
  reg         msg_q;
  reg         ack2_q;
  reg         toggle_q;
  reg  [10:0] code_q;
  reg  [15:0] rx_q;
  reg         partner_np_q;
  reg         partner_an_q;
  wire        page_rx_flag;
  wire        fault_flag;
  wire        exp_read;
  wire        tx_write;
  wire        exp_sel;
  wire        tx_sel;
  wire        rx_sel;
  reg  [15:0] exp_word;
  reg  [15:0] rdata_d;

  // Register decode
  assign exp_sel  = (reg_addr == `ADDR_EXPANSION);
  assign tx_sel   = (reg_addr == `ADDR_NP_TRANSMIT);
  assign rx_sel   = (reg_addr == `ADDR_PARTNER_NP);
  assign exp_read = reg_rd && exp_sel;
  assign tx_write = reg_wr && tx_sel;

  event_latch u_page_rx (
    .clk    (clk),
    .rst_n  (rst_n),
    .set    (page_rx_strobe),
    .clr    (exp_read),
    .flag_q (page_rx_flag)
  );

  event_latch u_par_fault (
    .clk    (clk),
    .rst_n  (rst_n),
    .set    (multi_tech_detect),
    .clr    (exp_read),
    .flag_q (fault_flag)
  );

  // Partner next-page ability hidden until its ability word is valid
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      partner_np_q <= `FLAG_RESET;
    end
    else
    begin
      partner_np_q <= partner_ability_valid & partner_np_able;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      partner_an_q <= `FLAG_RESET;
    end
    else
    begin
      partner_an_q <= partner_an_able;
    end
  end

  // Reserved bits read as zero
  always @*
  begin
    exp_word                      = `EXP_ZERO;
    exp_word[`EXP_PAR_FAULT_BIT]  = fault_flag;
    exp_word[`EXP_PARTNER_NP_BIT] = partner_np_q;
    exp_word[`EXP_LOCAL_NP_BIT]   = `LOCAL_NP_ABLE;
    exp_word[`EXP_PAGE_RX_BIT]    = page_rx_flag;
    exp_word[`EXP_PARTNER_AN_BIT] = partner_an_q;
  end

  // Transmit word fields other than toggle, each written only from management
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      more_q <= `NP_MORE_RESET;
    end
    else if (tx_write)
    begin
      more_q <= reg_wdata[`NP_MORE_BIT];
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      msg_q <= `NP_MSG_RESET;
    end
    else if (tx_write)
    begin
      msg_q <= reg_wdata[`NP_MSG_BIT];
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack2_q <= `NP_ACK2_RESET;
    end
    else if (tx_write)
    begin
      ack2_q <= reg_wdata[`NP_ACK2_BIT];
    end
  end

  // Toggle ignores writes so software cannot desync the exchange
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      toggle_q <= `NP_TOGGLE_RESET;
    end
    else if (page_tx_done)
    begin
      toggle_q <= ~toggle_q;
    end
  end

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      code_q <= `NP_CODE_RESET;
    end
    else if (tx_write)
    begin
      code_q <= reg_wdata[`NP_CODE_HI:`NP_CODE_LO];
    end
  end

  assign np_tx_word = {
    more_q,
    `NP_RSVD_ZERO,
    msg_q,
    ack2_q,
    toggle_q,
    code_q
  };

  // Received page captured per bit; reserved bit forced to zero
  genvar bit_idx;
  generate
    for (bit_idx = 0; bit_idx < `NP_WORD_WIDTH; bit_idx = bit_idx + 1)
    begin : g_rx_bit
      always @(posedge clk or negedge rst_n)
      begin
        if (!rst_n)
        begin
          rx_q[bit_idx] <= `NP_RX_RESET_BIT;
        end
        else if (page_rx_strobe)
        begin
          rx_q[bit_idx] <= (bit_idx == `NP_RSVD_BIT) ? `NP_RSVD_ZERO
                                                     : page_rx_word[bit_idx];
        end
      end
    end
  endgenerate

  // Unmapped registers read as zero
  always @*
  begin
    rdata_d = `RDATA_RESET;
    if (exp_sel)
      rdata_d = exp_word;
    if (tx_sel)
      rdata_d = np_tx_word;
    if (rx_sel)
      rdata_d = rx_q;
  end

  // Read data sampled before flags clear, so the read sees the latched event
  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= `RDATA_RESET;
    end
    else if (reg_rd)
    begin
      reg_rdata_q <= rdata_d;
    end
  end

endmodule

/* verif/np_checker_assertions.sv */
`timescale 1ns/1ps
module np_checker(input wire logic clk,rst_n,reg_rd,reg_wr,page_rx_strobe,page_tx_done,
  input wire logic[4:0]reg_addr,input wire logic[15:0]reg_wdata,reg_rdata_q,page_rx_word,
  np_tx_word);
  default clocking@(posedge clk);endclocking
  default disable iff(!rst_n);
  wire rd6=reg_rd&&reg_addr==5'h06;
  wire wr7=reg_wr&&reg_addr==5'h07;
  sequence s_pg(a);page_rx_strobe##1 reg_rd&&reg_addr==a&&!page_rx_strobe;endsequence
  a_np_cap:assert property(rd6|=>reg_rdata_q[2])else $error("cap");
  a_rx_flag:assert property(s_pg(5'h06)|=>reg_rdata_q[1])else $error("flag");
  a_rx_code:assert property(s_pg(5'h08)|=>reg_rdata_q[10:0]==$past(page_rx_word[10:0],2))
    else $error("code");
  a_tx_code:assert property(wr7|=>np_tx_word[10:0]==$past(reg_wdata[10:0]))
    else $error("wr");
  a_tx_rsvd:assert property(!np_tx_word[14])else $error("rsv");
  a_tg_flip:assert property(page_tx_done|=>$changed(np_tx_word[11]))else $error("tg");
  a_tg_hold:assert property(!page_tx_done|=>$stable(np_tx_word[11]))else $error("tg");
  a_rd_clear:assert property((rd6&&!page_rx_strobe)[*2]|=>!reg_rdata_q[1])
    else $error("clr");
endmodule
bind autoneg_next_page_registers np_checker i_np_checker(.*);

/* verif/page_partner.sv */
`timescale 1ns/1ps
module page_partner(input wire logic clk,output logic page_rx_strobe=0,
  output logic[15:0]page_rx_word=16'h0000);
  // Word inverted after strobe so stale data never looks valid
  task send(logic[15:0]w);
    {page_rx_strobe,page_rx_word}={1'b1,w};
    @(posedge clk);
    #1{page_rx_strobe,page_rx_word}={1'b0,~w};
  endtask
endmodule

/* verif/test_autoneg_next_page_registers.sv */
`timescale 1ns/1ps
module test_autoneg_next_page_registers;
  logic clk=0,rst_n=0,reg_wr=0,reg_rd=0,page_tx_done=0,multi_tech_detect=0,page_rx_strobe;
  logic partner_an_able=0,partner_ability_valid=0,partner_np_able=0;
  logic[4:0]reg_addr=0;
  logic[15:0]reg_wdata=0,reg_rdata_q,page_rx_word,np_tx_word;
  int err_total=0,cmp_count=0,cyc=0;
  autoneg_next_page_registers i_autoneg_next_page_registers(.*);
  page_partner i_page_partner(.*);
  initial forever #25 clk=~clk;
  always@(posedge clk)if(++cyc>300)begin err_total++;summarize;end
  task summarize;
    $display("%0d %0d",err_total,cmp_count);
    if(err_total==0&&cmp_count>0)$display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task chk(logic[15:0]s,e);
    cmp_count++;
    if(s!==e)begin err_total++;$display("Error %0t %h %h",$time,s,e);end
  endtask
  task step;@(posedge clk);#1;endtask
  task rd(logic[4:0]a,logic[15:0]e);
    reg_addr=a;reg_rd=1;step;chk(reg_rdata_q,e);reg_rd=0;step;
  endtask
  task t_tx;
    chk(np_tx_word,16'h2001);
    rd(6,16'h0004);
    rd(8,16'h0000);
    reg_addr=7;reg_wdata=16'hFFFF;reg_wr=1;step;reg_wr=0;
    chk(np_tx_word,16'hB7FF);
    page_tx_done=1;step;page_tx_done=0;
    rd(7,16'hBFFF);
  endtask
  task t_page;
    i_page_partner.send(16'hFFFF);
    rd(6,16'h0006);
    i_page_partner.send(16'h5A5A);
    rd(8,16'h1A5A);
  endtask
  task t_stat;
    partner_np_able=1;step;
    rd(6,16'h0006);
    {partner_an_able,partner_ability_valid,multi_tech_detect}=3'h7;
    step;multi_tech_detect=0;
    reg_addr=6;reg_rd=1;step;chk(reg_rdata_q,16'h001D);
    step;chk(reg_rdata_q,16'h000D);
    reg_rd=0;step;
    rd(9,16'h0000);
  endtask
  initial begin
    repeat(3)@(posedge clk);
    #1 rst_n=1;
    t_tx;t_page;t_stat;summarize;
  end
endmodule
